// >>> include/fwc_map.svh
// Purpose: Offsets, field positions, reset values and timing for the flash controller
// Assumes: Byte-wide special register port at the printed offsets
// Notes: Definitions only
`ifndef FWC_MAP_SVH
`define FWC_MAP_SVH
`define FWC_OFS_TIMING 8'hAB
`define FWC_OFS_ADDR_LOW 8'hAC
`define FWC_OFS_ADDR_HIGH 8'hAD
`define FWC_OFS_CMD_STATUS 8'hAE
`define FWC_OFS_WRITE_PORT 8'hAF
`define FWC_BIT_BUSY 7
`define FWC_BIT_PENDING 6
`define FWC_BIT_WRITE 1
`define FWC_BIT_ERASE 0
`define FWC_RST_TIMING 6'h11
`define FWC_DMA_TRIGGER_FLASH 5'h12
`define FWC_CLK_HZ 40000000
`define FWC_TIMEOUT_US 40
`define FWC_TIMEOUT_CYC ((`FWC_TIMEOUT_US * (`FWC_CLK_HZ / 1000000)))
`define FWC_WORD_UNITS 16
`define FWC_PAGE_UNITS 16000
`endif

// >>> include/fwc_pkg.sv
// Purpose: Types shared by the flash write/erase controller
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in fwc_map.svh
package fwc_pkg;
  typedef enum logic [2:0] {
    FWC_IDLE,
    FWC_ERASE,
    FWC_WAIT_BYTES,
    FWC_PROGRAM
  } fwc_state_e;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fwc_reg_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [13:0] addr;
    logic [15:0] data;
  } fwc_array_req_s;
endpackage

// >>> src/flash_write_erase_controller.sv
// Purpose: Flash program/erase sequencer with byte-pair write port and DMA request
// Assumes: Single system clock, synchronous reset, byte register port from the CPU
// Notes: Flash array is external; controller drives its request port
`timescale 1ns/1ps
`include "fwc_map.svh"

module flash_write_erase_controller
  import fwc_pkg::*;
#(
  parameter int TIMEOUT_CYC = `FWC_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire fwc_reg_req_s regReq,
  input wire logic cpuFlashAccess,
  input wire logic cpuRunsFromFlash,
  input wire logic dmaArmedFlash,
  input wire logic [4:0] dmaTriggerSelect,
  input wire logic sleepExit,
  input wire logic [15:0] arrayRdata,
  output logic [7:0] regRdata,
  output fwc_array_req_s arrayReq,
  output logic arrayEraseReq,
  output logic [4:0] arrayErasePage,
  output logic dmaReq,
  output logic cpuStall,
  output logic cpuFlashBlocked,
  output logic accessViolation
);
  typedef struct packed {
    fwc_state_e state;
    logic [5:0] addrHigh;
    logic [7:0] addrLow;
    logic [5:0] timingValue;
    logic [7:0] lowByte;
    logic haveLow;
    logic writeQueued;
    logic wordPending;
    logic [15:0] wordData;
    logic [15:0] toCount;
    logic [7:0] regRdata;
    fwc_array_req_s arrayReq;
    logic arrayEraseReq;
    logic [4:0] arrayErasePage;
    logic dmaReq;
    logic cpuStall;
    logic cpuFlashBlocked;
    logic accessViolation;
    logic tgStart;
    logic [15:0] tgUnits;
  } fwc_ctl_s;

  fwc_ctl_s st;
  fwc_ctl_s next_st;
  logic tgDone;
  logic busy;
  logic dmaUsed;
  logic portWrite;

  fwc_timing_gen #(
    .CNT_W(24)
  ) uTiming (
    .ref_clk(ref_clk),
    .srst(srst),
    .clkEn(clkEn),
    .start(st.tgStart),
    .units(st.tgUnits),
    .timingValue(st.timingValue),
    .done(tgDone)
  );

  assign busy = (st.state != FWC_IDLE);
  assign dmaUsed = dmaArmedFlash && (dmaTriggerSelect == `FWC_DMA_TRIGGER_FLASH);
  assign portWrite = regReq.wrEn && (regReq.addr == `FWC_OFS_WRITE_PORT);

  always_comb begin
    next_st = st;
    next_st.tgStart = 1'b0;
    next_st.arrayReq.req = 1'b0;
    next_st.arrayEraseReq = 1'b0;
    next_st.dmaReq = 1'b0;
    next_st.accessViolation = 1'b0;

    // Register writes; command bits are not stored in any readable field, so they read zero
    if (regReq.wrEn) begin
      unique case (regReq.addr)
        `FWC_OFS_TIMING: next_st.timingValue = regReq.wdata[5:0];
        `FWC_OFS_ADDR_LOW: next_st.addrLow = regReq.wdata;
        `FWC_OFS_ADDR_HIGH: next_st.addrHigh = regReq.wdata[5:0];
        `FWC_OFS_CMD_STATUS: begin
          if (!busy && regReq.wdata[`FWC_BIT_ERASE]) begin
            next_st.state = FWC_ERASE;
            next_st.writeQueued = regReq.wdata[`FWC_BIT_WRITE];
            next_st.arrayEraseReq = 1'b1;
            next_st.arrayErasePage = st.addrHigh[5:1];
            next_st.tgUnits = 16'(`FWC_PAGE_UNITS);
            next_st.tgStart = 1'b1;
            next_st.cpuStall = cpuRunsFromFlash;
          end else if (!busy && regReq.wdata[`FWC_BIT_WRITE]) begin
            next_st.state = FWC_WAIT_BYTES;
            next_st.haveLow = 1'b0;
            next_st.toCount = '0;
            next_st.dmaReq = dmaUsed;
            next_st.cpuStall = cpuRunsFromFlash && !dmaUsed;
          end
        end
        default: ;
      endcase
    end

    // Sleep exit drops a command in flight, unless a state step below moves it on in the same cycle
    if (sleepExit) begin
      next_st.state = FWC_IDLE;
      next_st.writeQueued = 1'b0;
      next_st.wordPending = 1'b0;
      next_st.cpuStall = 1'b0;
    end

    unique case (st.state)
      FWC_IDLE: ;
      FWC_ERASE: begin
        if (tgDone) begin
          next_st.writeQueued = 1'b0;
          if (st.writeQueued) begin
            next_st.state = FWC_WAIT_BYTES;
            next_st.haveLow = 1'b0;
            next_st.toCount = '0;
            next_st.dmaReq = dmaUsed;
          end else begin
            next_st.state = FWC_IDLE;
            next_st.cpuStall = 1'b0;
          end
        end
      end
      FWC_WAIT_BYTES: begin
        next_st.toCount = st.toCount + 16'h0001;
        if (portWrite) begin
          if (!st.haveLow) begin
            next_st.lowByte = regReq.wdata;
            next_st.haveLow = 1'b1;
            next_st.dmaReq = dmaUsed;
          end else begin
            // Read-modify-write so a one never revives a cleared bit
            next_st.wordData = {regReq.wdata, st.lowByte};
            next_st.haveLow = 1'b0;
            next_st.state = FWC_PROGRAM;
            next_st.wordPending = 1'b1;
            next_st.tgUnits = 16'(`FWC_WORD_UNITS);
            next_st.tgStart = 1'b1;
          end
        end else if (st.toCount >= 16'(TIMEOUT_CYC - 1)) begin
          // Address registers keep the failing word for resume
          next_st.state = FWC_IDLE;
          next_st.haveLow = 1'b0;
          next_st.cpuStall = 1'b0;
        end
      end
      FWC_PROGRAM: begin
        if (tgDone) begin
          next_st.arrayReq.req = 1'b1;
          next_st.arrayReq.we = 1'b1;
          next_st.arrayReq.addr = {st.addrHigh, st.addrLow};
          next_st.arrayReq.data = st.wordData & arrayRdata;
          {next_st.addrHigh, next_st.addrLow} = {st.addrHigh, st.addrLow} + 14'h0001;
          next_st.wordPending = 1'b0;
          next_st.state = FWC_WAIT_BYTES;
          next_st.toCount = '0;
          next_st.dmaReq = dmaUsed;
        end else begin
          // Hold array read address so the merge sees current contents
          next_st.arrayReq.addr = {st.addrHigh, st.addrLow};
          next_st.arrayReq.we = 1'b0;
        end
      end
      default: next_st.state = FWC_IDLE;
    endcase

    next_st.cpuFlashBlocked = (next_st.state == FWC_PROGRAM)
                              || (next_st.state == FWC_ERASE);
    next_st.accessViolation = cpuFlashAccess && st.wordPending;

    unique case (regReq.addr)
      `FWC_OFS_TIMING: next_st.regRdata = {2'b00, st.timingValue};
      `FWC_OFS_ADDR_LOW: next_st.regRdata = st.addrLow;
      `FWC_OFS_ADDR_HIGH: next_st.regRdata = {2'b00, st.addrHigh};
      `FWC_OFS_CMD_STATUS: next_st.regRdata = {busy, st.wordPending, 6'h00};
      `FWC_OFS_WRITE_PORT: next_st.regRdata = st.lowByte;
      default: next_st.regRdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
      st.timingValue <= `FWC_RST_TIMING;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign regRdata = st.regRdata;
  assign arrayReq = st.arrayReq;
  assign arrayEraseReq = st.arrayEraseReq;
  assign arrayErasePage = st.arrayErasePage;
  assign dmaReq = st.dmaReq;
  assign cpuStall = st.cpuStall;
  assign cpuFlashBlocked = st.cpuFlashBlocked;
  assign accessViolation = st.accessViolation;
endmodule

// >>> src/fwc_timing_gen.sv
// Purpose: Timing generator that scales program/erase durations by the timing value
// Assumes: Same clock and enable as the controller
// Notes: Duration is units times timing value system cycles, plus one
`timescale 1ns/1ps
module fwc_timing_gen
  import fwc_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [15:0] units,
  input wire logic [5:0] timingValue,
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic running;
    logic done;
  } fwc_tg_s;

  fwc_tg_s st;
  fwc_tg_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      // Zero timing value still takes one cycle
      next_st.count = CNT_W'(units) * CNT_W'(timingValue) + CNT_W'(1);
      next_st.running = 1'b1;
    end else if (st.running) begin
      if (st.count <= CNT_W'(1)) begin
        next_st.running = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule

// >>> testbench/flash_write_erase_controller_bench.sv
// Purpose: Self-checking bench for the flash write/erase controller
// Assumes: Timing value 1, so a word takes 17 cycles and a page 16001
// Notes: Short timeout parameter keeps the abort wait brief
`timescale 1ns/1ps
module flash_write_erase_controller_bench;
  import fwc_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cpuFlashAccess = 1'b0;
  logic dmaArmedFlash = 1'b0;
  logic [4:0] dmaTriggerSelect = 5'h00;
  fwc_reg_req_s regReq = '0;
  logic [15:0] arrayRdata;
  logic [7:0] regRdata;
  fwc_array_req_s arrayReq;
  logic arrayEraseReq;
  logic [4:0] arrayErasePage;
  logic dmaReq;
  logic cpuStall;
  logic cpuFlashBlocked;
  logic accessViolation;
  int bad_count = 0;
  int cmp_count = 0;
  int dmaCount = 0;
  int dmaSeen = 0;
  int violCount = 0;
  logic [29:0] progQ [$];
  logic [4:0] eraseQ [$];
  logic [15:0] d1, d2, d3;
  always #12.5 ref_clk = ~ref_clk;
  flash_write_erase_controller #(.TIMEOUT_CYC(40)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .clkEn(1'b1), .regReq(regReq), .cpuFlashAccess(cpuFlashAccess), .cpuRunsFromFlash(1'b0),
    .dmaArmedFlash(dmaArmedFlash), .dmaTriggerSelect(dmaTriggerSelect), .sleepExit(1'b0),
    .arrayRdata(arrayRdata), .regRdata(regRdata), .arrayReq(arrayReq),
    .arrayEraseReq(arrayEraseReq), .arrayErasePage(arrayErasePage), .dmaReq(dmaReq),
    .cpuStall(cpuStall), .cpuFlashBlocked(cpuFlashBlocked), .accessViolation(accessViolation));
  fwc_flash_model u_flash (.ref_clk(ref_clk), .arrayReq(arrayReq),
    .arrayEraseReq(arrayEraseReq), .arrayErasePage(arrayErasePage), .arrayRdata(arrayRdata));
  always @(posedge ref_clk) begin
    if (arrayReq.req) progQ.push_back({arrayReq.addr, arrayReq.data});
    if (arrayEraseReq) eraseQ.push_back(arrayErasePage);
    if (dmaReq) dmaCount++;
    if (accessViolation) violCount++;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    #1 regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 regReq.wrEn = 1'b0;
  endtask
  // Read data is registered, so valid one edge after the address; the task samples after two
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 regReq.addr = a;
    repeat (2) @(posedge ref_clk);
    #1 d = regRdata;
  endtask
  task automatic chk_rd(string name, logic [7:0] a, logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask
  task automatic wait_q(int n);
    int k = 0;
    while (progQ.size() < n && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    int k = 0;
    s = 8'h80;
    while (s[7] === 1'b1 && k < 8000) begin
      rd(8'hAE, s);
      k++;
    end
  endtask
  // Single byte transfer per trigger, fixed destination
  task automatic dma_byte(logic [7:0] d);
    int k = 0;
    while (dmaCount == dmaSeen && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    dmaSeen = dmaCount;
    wr(8'hAF, d);
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(48664));
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    d3 = 16'($urandom);
    repeat (12) @(posedge ref_clk);
    #1 srst = 1'b0;
    chk_rd("status", 8'hAE, 8'h00);
    chk_rd("timing", 8'hAB, 8'h11);
    chk_rd("unmapped", 8'h00, 8'h00);
    wr(8'hAB, 8'h01);
    wr(8'hAD, 8'h05);
    wr(8'hAC, 8'hFF);
    wr(8'hAE, 8'h01);
    wait_idle();
    check("eraseCount", eraseQ.size(), 1);
    check("erasePage", eraseQ[0], 5'h02);
    chk_rd("eraseDone", 8'hAE, 8'h00);
    wr(8'hAE, 8'h02);
    wr(8'hAF, d1[7:0]);
    wr(8'hAF, d1[15:8]);
    cpuFlashAccess = 1'b1;
    chk_rd("pending", 8'hAE, 8'hC0);
    cpuFlashAccess = 1'b0;
    check("blocked", cpuFlashBlocked, 1);
    check("noStall", cpuStall, 0);
    @(posedge ref_clk);
    #1 check("violation", violCount > 0, 1);
    wait_q(1);
    check("word0", progQ[0], {14'h05FF, d1});
    wr(8'hAF, d2[7:0]);
    wr(8'hAF, d2[15:8]);
    wait_q(2);
    check("word1", progQ[1], {14'h0600, d2 & 16'h5A5A});
    repeat (80) @(posedge ref_clk);
    chk_rd("timeout", 8'hAE, 8'h00);
    chk_rd("addrLow", 8'hAC, 8'h01);
    chk_rd("addrHigh", 8'hAD, 8'h06);
    dmaArmedFlash = 1'b1;
    dmaTriggerSelect = 5'h12;
    wr(8'hAD, 8'h05);
    wr(8'hAC, 8'hFF);
    dmaSeen = dmaCount;
    wr(8'hAE, 8'h02);
    dma_byte(d3[7:0]);
    dma_byte(d3[15:8]);
    wait_q(3);
    check("word2", progQ[2], {14'h05FF, d1 & d3});
    stop_test();
  end
endmodule

bind flash_write_erase_controller fwc_asserts u_chk (.ref_clk(ref_clk), .srst(srst),
  .cpuFlashAccess(cpuFlashAccess), .dmaArmedFlash(dmaArmedFlash),
  .dmaTriggerSelect(dmaTriggerSelect), .arrayRdata(arrayRdata), .arrayReq(arrayReq),
  .arrayEraseReq(arrayEraseReq), .dmaReq(dmaReq), .cpuStall(cpuStall),
  .cpuFlashBlocked(cpuFlashBlocked), .accessViolation(accessViolation));

// >>> testbench/fwc_asserts.sv
// Purpose: Port-level checks of the flash controller
// Assumes: One clock domain, synchronous reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module fwc_asserts
  import fwc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cpuFlashAccess,
  input wire logic dmaArmedFlash,
  input wire logic [4:0] dmaTriggerSelect,
  input wire logic [15:0] arrayRdata,
  input wire fwc_array_req_s arrayReq,
  input wire logic arrayEraseReq,
  input wire logic dmaReq,
  input wire logic cpuStall,
  input wire logic cpuFlashBlocked,
  input wire logic accessViolation
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  prog_pulse_a: assert property (arrayReq.req |=> !arrayReq.req)
    else $error("array program request longer than one cycle");
  clear_only_a: assert property (arrayReq.req |-> (arrayReq.data & ~arrayRdata) == 16'h0000)
    else $error("program would set a cleared bit");
  blocked_prog_a: assert property (arrayReq.req |-> $past(cpuFlashBlocked))
    else $error("flash not blocked during word program");
  erase_pulse_a: assert property (arrayEraseReq |=> !arrayEraseReq)
    else $error("erase request longer than one cycle");
  dma_trigger_a: assert property (dmaReq |-> dmaArmedFlash && dmaTriggerSelect == 5'h12)
    else $error("dma request without flash trigger armed");
  dma_pulse_a: assert property (dmaReq |=> !dmaReq)
    else $error("dma request longer than one cycle");
  viol_cause_a: assert property (accessViolation |-> $past(cpuFlashAccess))
    else $error("violation without a flash access");
  reset_idle_a: assert property ($fell(srst) |-> !cpuStall && !cpuFlashBlocked && !dmaReq)
    else $error("outputs not idle after reset");
endmodule

// >>> testbench/fwc_flash_model.sv
// Purpose: Behavioural flash array on the far side of the array request port
// Assumes: Array contents read back combinationally at the requested word
// Notes: Starts from a non-erased pattern so a missing erase shows up
`timescale 1ns/1ps
module fwc_flash_model
  import fwc_pkg::*;
(
  input wire logic ref_clk,
  input wire fwc_array_req_s arrayReq,
  input wire logic arrayEraseReq,
  input wire logic [4:0] arrayErasePage,
  output logic [15:0] arrayRdata
);
  logic [15:0] mem [0:16383];
  assign arrayRdata = mem[arrayReq.addr];
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 16'h5A5A;
    end
  end
  always @(posedge ref_clk) begin
    if (arrayReq.req && arrayReq.we) begin
      mem[arrayReq.addr] <= mem[arrayReq.addr] & arrayReq.data;
    end
    if (arrayEraseReq) begin
      for (int i = 0; i < 512; i++) begin
        mem[{arrayErasePage, i[8:0]}] <= 16'hFFFF;
      end
    end
  end
endmodule
